// File: src/tsc_pkg.sv
/*
  Shared constants and types for the time slot switch control block:
  control register layout, memory select codes, per-channel control bits,
  frame geometry, write-queue word and pin bundle.
  Assumes a single 40 MHz clock domain; all pins arrive asynchronous.
*/
package tsc_pkg;

  // frame geometry
  localparam int NSTREAM = 8;
  localparam int NCHAN = 32;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [4:0] CH_LAST = 5'h1F;
  localparam logic [4:0] CH_STEP = 5'h01;
  localparam logic [8:0] PHASE_STEP = 9'h001;

  // control register layout
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'hDF;
  localparam int CR_SPLIT = 7;
  localparam int CR_GLOBAL = 6;
  localparam int MS_HI = 4;
  localparam int MS_LO = 3;
  localparam int STA_HI = 2;
  localparam int STA_LO = 0;

  // memory select codes
  localparam logic [1:0] MEM_NONE = 2'h0;
  localparam logic [1:0] MEM_DATA = 2'h1;
  localparam logic [1:0] MEM_CML = 2'h2;
  localparam logic [1:0] MEM_PCC = 2'h3;

  // per-channel control word bits
  localparam int PCC_SRC = 2;
  localparam int PCC_CCO = 1;
  localparam int PCC_EN = 0;

  // connection memory low as a source address
  localparam int CML_STR_HI = 7;
  localparam int CML_STR_LO = 5;
  localparam int CML_CH_HI = 4;

  // address lines
  localparam int ADDR_TOP = 5;
  localparam int ADDR_CH_HI = 4;

  localparam int WQ_DEPTH = 4;

  typedef logic [7:0] tsc_mem_type [NSTREAM][NCHAN];

  typedef struct packed {
    logic [1:0] mem;
    logic [2:0] stream;
    logic [4:0] chan;
    logic [7:0] data;
  } tsc_wr_type;

  typedef struct packed {
    logic cs_n;
    logic ds;
    logic rw;
    logic [5:0] addr;
    logic [7:0] data;
    logic mde;
    logic c4;
    logic frame;
    logic [7:0] rx;
  } tsc_pin_type;

  typedef enum {PORT_IDLE, PORT_ACK} tsc_port_type;

endpackage

// File: src/tsc_switch.sv
/*
  Control logic of a 256-channel time slot switch: control register, address
  decode, per-channel output source and drive enable, side control output,
  and a small write queue in front of the connection memories.
  Assumes the serial clock, frame pulse, parallel port and drive enable pins
  are asynchronous to i_mclk (40 MHz) and steady for several mclk periods.
*/
module tsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW-1:0] ONE = AW'(1);
  localparam logic [CW-1:0] CONE = CW'(1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign o_in_ready = (cnt_r != FULL);
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data = mem_r[rp_r];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = i_in_data;
      wp_nxt = (wp_r == LAST) ? '0 : wp_r + ONE;
    end
    if (pop) begin
      rp_nxt = (rp_r == LAST) ? '0 : rp_r + ONE;
    end
    if (push & ~pop) begin
      cnt_nxt = cnt_r + CONE;
    end else if (pop & ~push) begin
      cnt_nxt = cnt_r - CONE;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      mem_r <= mem_nxt;
    end
  end
endmodule // tsc_fifo

// Notes on behaviour
// - with split access set, channel reads come from data memory and channel writes go to connection memory low.
// - with global direct output set, every channel behaves as if its source and enable bits were both high.
// - without global direct output, a channel whose source bit is high sends its connection memory low byte.
// - a channel whose source bit is low sends the data memory byte addressed by its connection memory low byte.
// - while the master drive enable pin is low, every serial output is floated.
// - with the master drive enable high and global direct output clear, a channel slot is driven only when its enable bit is high.
// - once per frame the control bit of all 256 per-channel words is shifted out on the side output.
// - each side output bit leads its channel by one channel, wrapping from channel 31 into the next frame.
// - within a channel the side bits of streams 0 to 7 for the next channel follow bit positions 7 to 0.
// - with the top address line low and the two lowest low the control register is reached, else top high picks a channel.
// - the memory select field routes channel accesses; data memory is read only and code zero reaches nothing.
// - the stream select field chooses the stream subsection that channel addresses index.
module tsc_switch
  import tsc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_cs_n,
  input wire logic i_ds,
  input wire logic i_rw,
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic i_master_drive_en,
  input wire logic i_c4,
  input wire logic i_frame,
  input wire logic [7:0] i_rx,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_dtack_n,
  output logic [7:0] o_tx,
  output logic [7:0] o_tx_oe,
  output logic o_cco
);

  // pin synchronisers with agreement filter
  tsc_pin_type pin_raw, s1_r, s2_r, s3_r, flt_r, flt_nxt;
  assign pin_raw = {i_cs_n, i_ds, i_rw, i_addr, i_data, i_master_drive_en, i_c4, i_frame, i_rx};

  always_comb begin
    flt_nxt = (s3_r & ~(s2_r ^ s3_r)) | (flt_r & (s2_r ^ s3_r));
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      flt_r <= '0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      flt_r <= flt_nxt;
    end
  end

  // frame phase: two serial clock edges per bit
  logic [8:0] ph_r, ph_nxt;
  logic c4_prev_r;
  logic c4_rise, bound, sample;
  logic [4:0] ch;
  logic [2:0] bp;

  assign c4_rise = flt_r.c4 & ~c4_prev_r;
  assign bound = c4_rise & ~ph_nxt[0];
  assign sample = c4_rise & ph_nxt[0];
  assign ch = ph_nxt[8:4];
  assign bp = ph_nxt[3:1];

  always_comb begin
    ph_nxt = ph_r;
    if (c4_rise) begin
      ph_nxt = flt_r.frame ? '0 : ph_r + PHASE_STEP;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ph_r <= '0;
      c4_prev_r <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
      c4_prev_r <= flt_r.c4;
    end
  end

  // memories
  tsc_mem_type dm_r, dm_nxt, cml_r, cml_nxt, pcc_r, pcc_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;

  function automatic logic [7:0] out_byte(input logic [2:0] s, input logic [4:0] c);
    logic [7:0] a;
    a = cml_r[s][c];
    if (ctrl_r[CR_GLOBAL] | pcc_r[s][c][PCC_SRC]) begin
      return a;
    end
    return dm_r[a[CML_STR_HI:CML_STR_LO]][a[CML_CH_HI:0]];
  endfunction

  function automatic logic out_en(input logic [2:0] s, input logic [4:0] c);
    return ctrl_r[CR_GLOBAL] | pcc_r[s][c][PCC_EN];
  endfunction

  function automatic logic [1:0] eff_mem(input logic rd);
    if (ctrl_r[CR_SPLIT]) begin
      return rd ? MEM_DATA : MEM_CML;
    end
    return ctrl_r[MS_HI:MS_LO];
  endfunction

  // serial side: receive, transmit, side control output
  logic [7:0] rx_sr_r [NSTREAM];
  logic [7:0] rx_sr_nxt [NSTREAM];
  logic [7:0] tx_byte_r [NSTREAM];
  logic [7:0] tx_byte_nxt [NSTREAM];
  logic [7:0] tx_en_r, tx_en_nxt, tx_bit_r, tx_bit_nxt, tx_oe_r, tx_oe_nxt;
  logic cco_r, cco_nxt;

  always_comb begin
    dm_nxt = dm_r;
    rx_sr_nxt = rx_sr_r;
    tx_byte_nxt = tx_byte_r;
    tx_en_nxt = tx_en_r;
    tx_bit_nxt = tx_bit_r;
    tx_oe_nxt = tx_oe_r;
    cco_nxt = cco_r;
    for (int s = 0; s < NSTREAM; s++) begin
      if (sample) begin
        rx_sr_nxt[s] = {rx_sr_r[s][6:0], flt_r.rx[s]};
        if (bp == BIT_LAST) begin
          dm_nxt[s][ch] = {rx_sr_r[s][6:0], flt_r.rx[s]};
        end
      end
      if (bound) begin
        if (bp == BIT_FIRST) begin
          tx_byte_nxt[s] = out_byte(3'(s), ch);
          tx_en_nxt[s] = out_en(3'(s), ch);
        end
        tx_bit_nxt[s] = tx_byte_nxt[s][BIT_LAST - bp];
      end
      tx_oe_nxt[s] = flt_r.mde & tx_en_nxt[s];
    end
    if (bound) begin
      cco_nxt = pcc_r[bp][5'(ch + CH_STEP)][PCC_CCO];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tx_en_r <= '0;
      tx_bit_r <= '0;
      tx_oe_r <= '0;
      cco_r <= 1'b0;
      for (int s = 0; s < NSTREAM; s++) begin
        rx_sr_r[s] <= '0;
        tx_byte_r[s] <= '0;
        for (int c = 0; c < NCHAN; c++) begin
          dm_r[s][c] <= '0;
        end
      end
    end else begin
      dm_r <= dm_nxt;
      rx_sr_r <= rx_sr_nxt;
      tx_byte_r <= tx_byte_nxt;
      tx_en_r <= tx_en_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_oe_r <= tx_oe_nxt;
      cco_r <= cco_nxt;
    end
  end

  assign o_tx = tx_bit_r;
  assign o_tx_oe = tx_oe_r;
  assign o_cco = cco_r;

  // write queue toward connection memories
  tsc_wr_type push_word, pop_word;
  logic push_valid, push_ready, pop_valid, pop_ready;

  assign pop_ready = ~c4_rise;

  tsc_fifo #(.WIDTH($bits(tsc_wr_type)), .DEPTH(WQ_DEPTH)) u_wq (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_in_valid(push_valid),
    .o_in_ready(push_ready),
    .i_in_data(push_word),
    .o_out_valid(pop_valid),
    .i_out_ready(pop_ready),
    .o_out_data(pop_word)
  );

  always_comb begin
    cml_nxt = cml_r;
    pcc_nxt = pcc_r;
    if (pop_valid & pop_ready) begin
      if (pop_word.mem == MEM_CML) begin
        cml_nxt[pop_word.stream][pop_word.chan] = pop_word.data;
      end else begin
        pcc_nxt[pop_word.stream][pop_word.chan] = pop_word.data;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      for (int s = 0; s < NSTREAM; s++) begin
        for (int c = 0; c < NCHAN; c++) begin
          cml_r[s][c] <= '0;
          pcc_r[s][c] <= '0;
        end
      end
    end else begin
      cml_r <= cml_nxt;
      pcc_r <= pcc_nxt;
    end
  end

  // parallel port
  tsc_port_type state_r, state_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic rd_oe_r, rd_oe_nxt, dtack_n_r, dtack_n_nxt;
  logic strobe, is_ctrl, is_chan, wr_ok;
  logic [1:0] mem_sel;
  logic [2:0] str_sel;
  logic [4:0] ch_sel;

  assign strobe = ~flt_r.cs_n & flt_r.ds;
  assign is_ctrl = ~flt_r.addr[ADDR_TOP] & ~flt_r.addr[1] & ~flt_r.addr[0];
  assign is_chan = flt_r.addr[ADDR_TOP];
  assign mem_sel = eff_mem(flt_r.rw);
  assign str_sel = ctrl_r[STA_HI:STA_LO];
  assign ch_sel = flt_r.addr[ADDR_CH_HI:0];
  assign wr_ok = (mem_sel == MEM_CML) | (mem_sel == MEM_PCC);
  assign push_word = '{mem: mem_sel, stream: str_sel, chan: ch_sel, data: flt_r.data};

  always_comb begin
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    rd_data_nxt = rd_data_r;
    rd_oe_nxt = rd_oe_r;
    dtack_n_nxt = dtack_n_r;
    push_valid = 1'b0;
    unique case (state_r)
      PORT_IDLE: begin
        if (strobe & flt_r.rw & ~pop_valid) begin
          rd_data_nxt = '0;
          if (is_ctrl) begin
            rd_data_nxt = ctrl_r;
          end else if (is_chan) begin
            unique case (mem_sel)
              MEM_DATA: rd_data_nxt = dm_r[str_sel][ch_sel];
              MEM_CML: rd_data_nxt = cml_r[str_sel][ch_sel];
              MEM_PCC: rd_data_nxt = pcc_r[str_sel][ch_sel];
              MEM_NONE: rd_data_nxt = '0;
            endcase
          end
          rd_oe_nxt = 1'b1;
          dtack_n_nxt = 1'b0;
          state_nxt = PORT_ACK;
        end else if (strobe & ~flt_r.rw) begin
          push_valid = is_chan & wr_ok;
          if (~push_valid | push_ready) begin
            if (is_ctrl) begin
              ctrl_nxt = flt_r.data & CTRL_MASK;
            end
            dtack_n_nxt = 1'b0;
            state_nxt = PORT_ACK;
          end
        end
      end
      PORT_ACK: begin
        if (~strobe) begin
          rd_oe_nxt = 1'b0;
          dtack_n_nxt = 1'b1;
          state_nxt = PORT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_r <= PORT_IDLE;
      ctrl_r <= CTRL_RESET;
      rd_data_r <= '0;
      rd_oe_r <= 1'b0;
      dtack_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      rd_data_r <= rd_data_nxt;
      rd_oe_r <= rd_oe_nxt;
      dtack_n_r <= dtack_n_nxt;
    end
  end

  assign o_data = rd_data_r;
  assign o_data_oe = rd_oe_r;
  assign o_dtack_n = dtack_n_r;

  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  sequence s_load0;
    bound && (bp == BIT_FIRST);
  endsequence

  sequence s_ctrl_write;
    (state_r == PORT_IDLE) && strobe && !flt_r.rw && is_ctrl;
  endsequence

  a_ctrl_reset:
    assert property ($past(i_srst) |-> ctrl_r == CTRL_RESET) else $error("control not cleared by reset");
  a_split_route:
    assert property (ctrl_r[CR_SPLIT] && push_valid |-> push_word.mem == MEM_CML) else $error("split write misrouted");
  a_global_force:
    assert property (s_load0 ##0 (ctrl_r[CR_GLOBAL] && flt_r.mde) |=> o_tx_oe == 8'hFF)
      else $error("global direct output not driving");
  a_direct_byte:
    assert property (s_load0 ##0 (ctrl_r[CR_GLOBAL] || pcc_r[0][ch][PCC_SRC]) |=> tx_byte_r[0] == $past(cml_r[0][ch]))
      else $error("direct byte wrong");
  a_switched_byte:
    assert property (s_load0 ##0 (!ctrl_r[CR_GLOBAL] && !pcc_r[0][ch][PCC_SRC])
      |=> tx_byte_r[0] == $past(dm_r[cml_r[0][ch][CML_STR_HI:CML_STR_LO]][cml_r[0][ch][CML_CH_HI:0]]))
      else $error("switched byte wrong");
  a_master_off:
    assert property (!flt_r.mde |=> o_tx_oe == 8'h00) else $error("output driven with master enable low");
  a_chan_enable:
    assert property (s_load0 ##0 (flt_r.mde && !ctrl_r[CR_GLOBAL]) |=> o_tx_oe[0] == $past(pcc_r[0][ch][PCC_EN]))
      else $error("channel enable not followed");
  a_cco_lead:
    assert property (bound |=> o_cco == $past(pcc_r[bp][5'(ch + CH_STEP)][PCC_CCO])) else $error("side bit wrong");
  a_cco_wrap:
    assert property (bound && ch == CH_LAST && bp == BIT_LAST |=> o_cco == $past(pcc_r[7][0][PCC_CCO]))
      else $error("side bit wrap wrong");
  a_ctrl_decode:
    assert property (s_ctrl_write |=> ctrl_r == ($past(flt_r.data) & CTRL_MASK) && !o_dtack_n)
      else $error("control write not taken");
  a_mem_select:
    assert property (push_valid && !ctrl_r[CR_SPLIT] |-> push_word.mem == ctrl_r[MS_HI:MS_LO]
      && push_word.mem != MEM_DATA && push_word.stream == ctrl_r[STA_HI:STA_LO])
      else $error("channel write routed wrongly");

endmodule // tsc_switch

// File: tb/tsc_host_model.sv
/*
  Host processor model on the parallel port: byte accesses and the
  master drive enable pin.
  Assumes i_mclk at 40 MHz; pins change only at its falling edge.
*/
module tsc_host_model
  import tsc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_dtack_n,
  input wire logic [7:0] i_rdata,
  output logic o_cs_n,
  output logic o_ds,
  output logic o_rw,
  output logic [5:0] o_addr,
  output logic [7:0] o_data,
  output logic o_mde
);
  timeunit 1ns;
  timeprecision 1ps;
  int late = 0;

  initial begin
    o_cs_n = 1'b1;
    o_ds = 1'b0;
    o_rw = 1'b1;
    o_addr = 6'h00;
    o_data = 8'h00;
    o_mde = 1'b0;
  end

  // drivers released until paths are programmed
  task automatic set_mde(input logic v);
    @(negedge i_mclk);
    o_mde = v;
  endtask

  // one byte access, held until acknowledged, then released
  task automatic acc(input logic rd, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(negedge i_mclk);
    o_cs_n = 1'b0;
    o_ds = 1'b1;
    o_rw = rd;
    o_addr = a;
    if (!rd) o_data = d;
    n = 0;
    while (i_dtack_n !== 1'b0 && n < 400) begin
      @(negedge i_mclk);
      n++;
    end
    if (n >= 400) late++;
    q = i_rdata;
    o_cs_n = 1'b1;
    o_ds = 1'b0;
    o_addr = ~a;
    o_data = ~o_data;
    n = 0;
    while (i_dtack_n !== 1'b1 && n < 400) begin
      @(negedge i_mclk);
      n++;
    end
    if (n >= 400) late++;
  endtask
endmodule // tsc_host_model

// File: tb/tsc_switch_tb_top.sv
/*
  Self-checking bench for the switch control block: register tests over
  the parallel port, serial frame generator and output capture.
  Assumes tsc_host_model drives the port; serial clock is made here.
*/
module tsc_switch_tb_top
  import tsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk, i_srst, i_c4, i_frame, cs_n, ds, rw, mde, o_data_oe, o_dtack_n, o_cco;
  logic [5:0] addr;
  logic [7:0] i_rx, wdata, o_data, o_tx, o_tx_oe, q;
  logic [7:0] txc [8][32];
  logic [31:0] oew [8], ccw [8], eoe [8], ecc [8];
  logic [13:0] prog [11] = '{{6'h00, 8'h10}, {6'h22, 8'h5A}, {6'h23, 8'h27}, {6'h25, 8'h07}, {6'h00, 8'h18},
    {6'h20, 8'h02}, {6'h22, 8'h07}, {6'h23, 8'h01}, {6'h25, 8'h01}, {6'h00, 8'h1D}, {6'h2A, 8'h02}};
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t = 0;

  tsc_switch dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_cs_n(cs_n), .i_ds(ds), .i_rw(rw), .i_addr(addr),
    .i_data(wdata), .i_master_drive_en(mde), .i_c4(i_c4), .i_frame(i_frame), .i_rx(i_rx), .o_data(o_data),
    .o_data_oe(o_data_oe), .o_dtack_n(o_dtack_n), .o_tx(o_tx), .o_tx_oe(o_tx_oe), .o_cco(o_cco));
  tsc_host_model host (.i_mclk(i_mclk), .i_dtack_n(o_dtack_n), .i_rdata(o_data), .o_cs_n(cs_n), .o_ds(ds),
    .o_rw(rw), .o_addr(addr), .o_data(wdata), .o_mde(mde));

  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  // serial clock, frame pulse and capture at mid bit
  always @(negedge i_mclk) begin
    int p, ch, b;
    p = t % 5120;
    i_c4 = (p % 10) < 5;
    i_frame = (p < 5) || (p >= 5115);
    if (p % 20 == 15) begin
      ch = p / 160;
      b = (p / 20) % 8;
      for (int s = 0; s < 8; s++) begin
        txc[s][ch][7-b] = o_tx[s];
        if (b == 3) oew[s][ch] = o_tx_oe[s];
      end
      ccw[b][ch] = o_cco;
    end
    t = t + 1;
  end

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 70000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.acc(1'b0, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    host.acc(1'b1, a, 8'h00, q);
    chk(32'(q), 32'(e));
    chk(32'(o_data_oe), 32'h0);
  endtask

  task automatic frames(input int n);
    repeat (n * 5120) @(negedge i_mclk);
  endtask

  task automatic scheck();
    for (int s = 0; s < 8; s++) begin
      chk(oew[s], eoe[s]);
      chk(ccw[s], ecc[s]);
    end
  endtask

  task automatic tend(input string n);
    $display("test %s done", n);
  endtask

  task automatic stop_test();
    err_total += host.late;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    i_srst = 1'b1;
    i_c4 = 1'b0;
    i_frame = 1'b0;
    i_rx = 8'hA5;
    repeat (5) @(negedge i_mclk);
    i_srst = 1'b0;
    repeat (2) @(negedge i_mclk);
    rd(6'h00, CTRL_RESET);
    wr(6'h00, 8'hFF);
    rd(6'h1C, CTRL_MASK);
    wr(6'h01, 8'h00);
    rd(6'h00, CTRL_MASK);
    rd(6'h02, 8'h00);
    wr(6'h00, 8'h13);
    wr(6'h25, 8'hA5);
    wr(6'h00, 8'h1B);
    wr(6'h25, 8'h06);
    rd(6'h25, 8'h06);
    wr(6'h00, 8'h13);
    rd(6'h25, 8'hA5);
    wr(6'h00, 8'h12);
    rd(6'h25, 8'h00);
    tend("registers");
    // only stream 0 slots get drivers, so no shared bus clash
    for (int i = 0; i < 11; i++) wr(prog[i][13:8], prog[i][7:0]);
    frames(2);
    for (int s = 0; s < 8; s++) begin
      eoe[s] = 32'h0000_0000;
      ecc[s] = 32'h0000_0000;
    end
    ecc[0] = 32'h8000_0002;
    ecc[3] = 32'h0000_0010;
    ecc[5] = 32'h0000_0200;
    scheck();
    wr(6'h00, 8'h08);
    rd(6'h27, 8'hFF);
    wr(6'h00, 8'h09);
    wr(6'h27, 8'h55);
    rd(6'h27, 8'h00);
    wr(6'h00, 8'h00);
    rd(6'h22, 8'h00);
    wr(6'h00, 8'h98);
    wr(6'h29, 8'h3C);
    rd(6'h29, 8'hFF);
    wr(6'h00, 8'h10);
    rd(6'h29, 8'h3C);
    wr(6'h00, 8'h18);
    rd(6'h29, 8'h00);
    tend("memories");
    host.set_mde(1'b1);
    frames(2);
    eoe[0] = 32'h0000_002C;
    scheck();
    chk(32'(txc[0][2]), 32'h5A);
    chk(32'(txc[0][3]), 32'h00);
    chk(32'(txc[0][5]), 32'hFF);
    tend("drive");
    wr(6'h00, 8'h40);
    frames(2);
    for (int s = 0; s < 8; s++) eoe[s] = 32'hFFFF_FFFF;
    scheck();
    chk(32'(txc[0][3]), 32'h27);
    chk(32'(txc[3][5]), 32'hA5);
    chk(32'(txc[0][9]), 32'h3C);
    tend("global");
    host.set_mde(1'b0);
    frames(2);
    for (int s = 0; s < 8; s++) eoe[s] = 32'h0000_0000;
    scheck();
    tend("float");
    stop_test();
  end
endmodule // tsc_switch_tb_top
